// >>> pkg/tsf_pkg.sv
/*
 * Constants and carrier types for the transaction status flag bank.
 * Assumes one 100 MHz clock domain and an APB master on the register side.
 */
//
// Overview of operation
// - each source's done flag is set when its transaction completes and cleared when it begins.
// - every done flag powers up as one and is forced to one on each bus reset.
// - done flags sit at bits 0-4 and 6, error flags eight bits higher, retry flags at bits 16-20.
// - the data transmit error flag is set on an errored end and also on an abort of that transfer.
// - an error flag is set on an errored end and cleared on a clean end or a new begin.
// - data transmit and data receive error flags reset to zero and hold their value across bus reset.
// - the other error flags reset to zero and are cleared on each bus reset.
// - a retry flag is set when its source starts retrying after a busy acknowledge.
// - a retry flag is cleared when the retry ends on a non-busy acknowledge, a time-out or a bus reset.
// - every retry flag powers up as zero and is cleared on each bus reset.
// - a bus reset alters no other bit of the status register.
package tsf_pkg;

   localparam int unsigned NSRC          = 6;      // sources, autoresponse last
   localparam logic [11:0] TTCS_OFFSET   = 12'h060;
   localparam logic [11:0] IRQ_STAT_OFF  = 12'h070;
   localparam logic [11:0] IRQ_MASK_OFF  = 12'h074;
   localparam int unsigned DONE_POS      = 0;
   localparam int unsigned ERR_POS       = 8;
   localparam int unsigned RETRY_POS     = 16;
   localparam logic [5:0]  DONE_RESET    = 6'h3F;
   localparam logic [5:0]  ERR_RESET     = 6'h00;
   localparam logic [4:0]  RETRY_RESET   = 5'h00;
   localparam logic [5:0]  ERR_KEEP_BRST = 6'h03;  // data tx and data rx errors survive bus reset
   localparam logic [5:0]  IRQ_RESET     = 6'h00;

   // per-source event strobes from the transmit engine
   typedef struct packed {
      logic [5:0] begin_x;   // transaction begins
      logic [5:0] end_ok;    // ends without errors
      logic [5:0] end_err;   // ends with errors
      logic [4:0] retry_go;  // busy ack received, retry starts
      logic [4:0] retry_end; // non-busy ack or retry time-out
      logic       abort_dt;  // abort of the data transmit transfer
      logic       bus_reset;
   } tsf_events_t;

   // packs the flag vectors into register image; gaps read as zero
   function automatic logic [31:0] tsf_image(input logic [5:0] done, input logic [5:0] err,
                                             input logic [4:0] rtry);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[DONE_POS +: 5] = done[4:0];
      w[DONE_POS + 6]  = done[5];
      w[ERR_POS +: 5]  = err[4:0];
      w[ERR_POS + 6]   = err[5];
      w[RETRY_POS +: 5] = rtry;
      return w;
   endfunction : tsf_image

endpackage : tsf_pkg

// >>> hdl/tsf_status_flags.sv
/*
 * Transaction status flag bank with APB slave and a sticky interrupt.
 * Assumes event strobes are one-cycle pulses from logic on clk_in.
 */
`timescale 1ns/1ps
module tsf_status_flags (
   // clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 rst_n_in,
   // transmit engine events
   input  wire tsf_pkg::tsf_events_t ev_in,
   // apb slave
   input  wire logic                 psel_in,
   input  wire logic                 penable_in,
   input  wire logic                 pwrite_in,
   input  wire logic [11:0]          paddr_in,
   input  wire logic [31:0]          pwdata_in,
   output logic                      pready_out,
   output logic                      pslverr_out,
   output logic [31:0]               prdata_out,
   // interrupt
   output logic                      irq_out
);

   ////////////////////////////////////////////////////////////////////////
   // flag state
   logic [5:0] done_q, done_d;
   logic [5:0] err_q, err_d;
   logic [4:0] rtry_q, rtry_d;
   logic [5:0] irq_stat_q, irq_stat_d;
   logic [5:0] irq_mask_q, irq_mask_d;
   logic [31:0] prdata_q, prdata_d;
   logic        pslverr_q, pslverr_d;

   // bus reset forces done high; otherwise completion sets, begin clears
   assign done_d = ev_in.bus_reset ? tsf_pkg::DONE_RESET
                 : (done_q & ~ev_in.begin_x) | ev_in.end_ok | ev_in.end_err;

   // errored end or abort sets; clean end or begin clears; set wins
   wire [5:0] err_set = ev_in.end_err | {5'h00, ev_in.abort_dt};
   wire [5:0] err_clr = ev_in.end_ok | ev_in.begin_x;
   wire [5:0] err_ev  = (err_q & ~err_clr) | err_set;
   assign err_d = ev_in.bus_reset ? (err_ev & tsf_pkg::ERR_KEEP_BRST)
                                  : err_ev;

   // busy ack starts a retry; non-busy ack, time-out or bus reset ends it
   assign rtry_d = ev_in.bus_reset ? tsf_pkg::RETRY_RESET
                 : (rtry_q & ~ev_in.retry_end) | ev_in.retry_go;

   // flags only change on events; host writes never reach them
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         done_q <= tsf_pkg::DONE_RESET;
         err_q  <= tsf_pkg::ERR_RESET;
         rtry_q <= tsf_pkg::RETRY_RESET;
      end else begin
         done_q <= done_d;
         err_q  <= err_d;
         rtry_q <= rtry_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb decode, zero wait states
   wire        wr_acc   = psel_in & penable_in & pwrite_in;
   wire        rd_acc   = psel_in & penable_in & ~pwrite_in;
   wire        hit_ttcs = (paddr_in == tsf_pkg::TTCS_OFFSET);
   wire        hit_stat = (paddr_in == tsf_pkg::IRQ_STAT_OFF);
   wire        hit_mask = (paddr_in == tsf_pkg::IRQ_MASK_OFF);
   wire        hit_any  = hit_ttcs | hit_stat | hit_mask;
   wire [31:0] img      = tsf_pkg::tsf_image(done_q, err_q, rtry_q);

   // read data registered at the setup phase so it is stable in the access phase
   wire        setup_rd = psel_in & ~penable_in & ~pwrite_in;
   assign prdata_d = ~setup_rd ? prdata_q
                   : hit_ttcs ? img
                   : hit_stat ? {26'h0000000, irq_stat_q}
                   : hit_mask ? {26'h0000000, irq_mask_q}
                   : 32'h0000_0000;
   assign pslverr_d = setup_rd | (psel_in & ~penable_in) ? ~hit_any : pslverr_q;

   ////////////////////////////////////////////////////////////////////////
   // interrupt: rising edges of done and error flags, write one to clear
   wire [5:0] irq_ev  = (done_d & ~done_q) | (err_d & ~err_q);
   wire [5:0] w1c     = (wr_acc & hit_stat) ? pwdata_in[5:0] : 6'h00;
   assign irq_stat_d = (irq_stat_q & ~w1c) | irq_ev;   // set beats clear
   assign irq_mask_d = (wr_acc & hit_mask) ? pwdata_in[5:0] : irq_mask_q;

   // bus side registers; write to the status word itself is dropped
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_stat_q <= tsf_pkg::IRQ_RESET;
         irq_mask_q <= tsf_pkg::IRQ_RESET;
         prdata_q   <= 32'h0000_0000;
         pslverr_q  <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         prdata_q   <= prdata_d;
         pslverr_q  <= pslverr_d;
      end
   end

   assign pready_out  = 1'b1;
   assign pslverr_out = pslverr_q & psel_in & penable_in;
   assign prdata_out  = prdata_q;
   assign irq_out     = |(irq_stat_q & irq_mask_q);

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   done_on_brst_a: assert property (ev_in.bus_reset |=> done_q == 6'h3F)
      else $error("done flags not forced high by bus reset");
   done_begin_a: assert property ((ev_in.begin_x[0] & ~ev_in.end_ok[0] & ~ev_in.end_err[0]
                                  & ~ev_in.bus_reset) |=> !done_q[0])
      else $error("done flag not cleared on begin");
   done_end_a: assert property (ev_in.end_err[3] |=> done_q[3])
      else $error("done flag not set on end");
   abort_err_a: assert property (ev_in.abort_dt |=> err_q[0])
      else $error("abort did not set data tx error");
   err_set_a: assert property (ev_in.end_err[2] & ~ev_in.bus_reset |=> err_q[2])
      else $error("error flag not set on errored end");
   err_clean_a: assert property ((ev_in.end_ok[5] & ~ev_in.end_err[5]) |=> !err_q[5])
      else $error("error flag not cleared on clean end");
   err_keep_a: assert property ((ev_in.bus_reset & ~|err_set & ~|err_clr)
                                |=> err_q[1:0] == $past(err_q[1:0]) && err_q[5:2] == 4'h0)
      else $error("bus reset handling of error flags wrong");
   rtry_set_a: assert property (ev_in.retry_go[4] & ~ev_in.bus_reset |=> rtry_q[4])
      else $error("retry flag not set");
   rtry_end_a: assert property ((ev_in.retry_end[1] & ~ev_in.retry_go[1]) |=> !rtry_q[1])
      else $error("retry flag not cleared");
   rtry_brst_a: assert property (ev_in.bus_reset |=> rtry_q == 5'h00 && err_q[4:2] == 3'h0)
      else $error("bus reset did not clear retry flags");
   rsvd_zero_a: assert property (img[7] == 1'b0 && img[5] == 1'b0 && img[15] == 1'b0
                                 && img[13] == 1'b0 && img[31:21] == 11'h000)
      else $error("reserved bit reads nonzero");
   quiet_hold_a: assert property ((ev_in == '0) |=> $stable(img))
      else $error("status changed without an event");

   ////////////////////////////////////////////////////////////////////////
   // per-source checks, so that every bit of each flag vector is watched and not just one sample index
   for (genvar i = 0; i < 6; i++) begin : g_src_chk
      // a lone begin must clear done, whatever source it comes from
      src_begin_a: assert property ((ev_in.begin_x[i] & ~ev_in.end_ok[i] & ~ev_in.end_err[i]
                                    & ~ev_in.bus_reset) |=> !done_q[i])
         else $error("done flag not cleared on begin of a source");
      // a clean end must raise done
      src_end_a: assert property (ev_in.end_ok[i] |=> done_q[i])
         else $error("done flag not set on clean end of a source");
      // an errored end must raise the error flag unless bus reset wipes it
      src_err_a: assert property ((ev_in.end_err[i] & (~ev_in.bus_reset | tsf_pkg::ERR_KEEP_BRST[i]))
                                  |=> err_q[i])
         else $error("error flag not set on errored end of a source");
      // a begin with no error event in the same cycle must clear the error flag
      src_errclr_a: assert property ((ev_in.begin_x[i] & ~ev_in.end_err[i]
                                     & ~(ev_in.abort_dt & (i == 0))) |=> !err_q[i])
         else $error("error flag not cleared on begin of a source");
   end

   for (genvar j = 0; j < 5; j++) begin : g_rtry_chk
      // retry start must show next cycle unless bus reset intervenes
      src_rtry_a: assert property ((ev_in.retry_go[j] & ~ev_in.bus_reset) |=> rtry_q[j])
         else $error("retry flag not set for a source");
      // retry end without a new start must clear the flag
      src_rtend_a: assert property ((ev_in.retry_end[j] & ~ev_in.retry_go[j]) |=> !rtry_q[j])
         else $error("retry flag not cleared for a source");
   end

   // a write of ones to the interrupt status, in a cycle with no new event on any bit, clears those bits
   w1c_clear_a: assert property ((wr_acc & hit_stat & ~|irq_ev) |=> ((irq_stat_q & $past(pwdata_in[5:0])) == 6'h00))
      else $error("interrupt status not cleared by write of one");
   // status word writes must leave the flags alone
   ttcs_wr_a: assert property ((wr_acc & hit_ttcs & (ev_in == '0)) |=> $stable(img))
      else $error("host write altered the status flags");

   retry_seen_c: cover property (ev_in.retry_go[0] ##[1:20] ev_in.retry_end[0]);
   abort_seen_c: cover property (ev_in.abort_dt);
   irq_seen_c:   cover property ($rose(irq_out));
   brst_seen_c:  cover property (ev_in.bus_reset ##1 ev_in.begin_x[2]);

endmodule : tsf_status_flags

// >>> verification/tsf_engine_model.sv
/*
 * Transmit engine stand-in that drives the event strobes of the flag bank.
 * Assumes the bench presents each request for exactly one cycle on clk_in.
 */
`timescale 1ns/1ps
module tsf_engine_model (
   // clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 rst_n_in,
   // request in, event strobes out
   input  wire tsf_pkg::tsf_events_t ev_req_in,
   output tsf_pkg::tsf_events_t      ev_out
);
   // registered so strobes change just after an edge, as real engine logic would
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ev_out <= '0;
      end else begin
         ev_out <= ev_req_in;
      end
   end
endmodule : tsf_engine_model

// >>> verification/transaction_status_flags_tb.sv
/*
 * Random event bench for the status flag bank, checked against an integer model.
 * Assumes a zero-wait apb slave and one-cycle strobes from the engine model.
 */
`timescale 1ns/1ps
module transaction_status_flags_tb;
   logic                 clk_in = 1'b0;
   logic                 rst_n_in = 1'b0;
   logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready_out, pslverr_out, irq_out, se;
   logic [11:0]          paddr = 12'h000;
   logic [31:0]          pwdata = 32'h0000_0000, prdata_out, rd, seed = 32'h0000_610C;
   tsf_pkg::tsf_events_t ev_req = '0, ev, e;
   int                   err_total = 0, comparisons = 0, done = 'h3F, err = 0, rtry = 0, istat = 0, imask = 0;
   tsf_engine_model eng (.clk_in(clk_in), .rst_n_in(rst_n_in), .ev_req_in(ev_req), .ev_out(ev));
   tsf_status_flags dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ev_in(ev), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .prdata_out(prdata_out), .irq_out(irq_out));
   always #5 clk_in = ~clk_in;
   ////////////////////////////////////////////////////////////////////////////
   // helpers: random source, reference model, bus cycle, compare, verdict
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [31:0] image();
      return 32'(rtry << 16 | (err & 'h1F) << 8 | (err >> 5) << 14 | (done & 'h1F) | (done >> 5) << 6);
   endfunction : image
   // same-cycle priorities: end beats begin, error set beats clear, retry start beats end
   task automatic model(input tsf_pkg::tsf_events_t v);
      int nd, ne, nr;
      nd = done;
      ne = err;
      nr = rtry;
      for (int i = 0; i < 6; i++) begin
         if (v.end_ok[i] | v.end_err[i]) nd[i] = 1; else if (v.begin_x[i]) nd[i] = 0;
         if (v.end_err[i] | (i == 0 && v.abort_dt)) ne[i] = 1; else if (v.end_ok[i] | v.begin_x[i]) ne[i] = 0;
         if (i < 5 && v.retry_go[i]) nr[i] = 1; else if (i < 5 && v.retry_end[i]) nr[i] = 0;
      end
      if (v.bus_reset) begin
         nd = 'h3F;
         nr = 0;
         ne = ne & 'h3;
      end
      istat |= (nd & ~done) | (ne & ~err);
      done = nd;
      err = ne;
      rtry = nr;
   endtask : model
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_in);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
      @(posedge clk_in);
      penable <= 1'b1;
      do begin @(posedge clk_in); n++; end while (pready_out !== 1'b1 && n < 20);
      if (pready_out !== 1'b1) begin
         err_total++;
         $display("BAD t=%0t no ready from the slave", $time);
      end
      rd = prdata_out;
      se = pslverr_out;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////////
   // main sequence: reset image, ignored writes, unmapped access, random events
   initial begin
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      apb(1'b0, tsf_pkg::TTCS_OFFSET, 32'h0000_0000);
      chk(rd, 32'h0000_005F);
      chk({31'h0, se}, 32'h0000_0000);
      apb(1'b1, tsf_pkg::TTCS_OFFSET, 32'hFFFF_FFFF);
      apb(1'b0, tsf_pkg::TTCS_OFFSET, 32'h0000_0000);
      chk(rd, 32'h0000_005F);
      apb(1'b0, 12'h0F0, 32'h0000_0000);
      chk({rd[31:1], se}, 32'h0000_0001);
      for (int k = 0; k < 80; k++) begin
         seed = xs(seed);
         e = tsf_pkg::tsf_events_t'({seed[29:1], seed[0] & seed[31] & seed[30]});
         ev_req <= e;
         model(e);
         @(posedge clk_in);
         ev_req <= '0;
         repeat (2) @(posedge clk_in);
         apb(1'b0, tsf_pkg::TTCS_OFFSET, 32'h0000_0000);
         chk(rd, image());
         apb(1'b1, tsf_pkg::IRQ_MASK_OFF, {26'h0, seed[31:26]});
         imask = int'(seed[31:26]);
         apb(1'b1, tsf_pkg::IRQ_STAT_OFF, {26'h0, seed[21:16]});
         istat = istat & ~int'(seed[21:16]);
         apb(1'b0, tsf_pkg::IRQ_STAT_OFF, 32'h0000_0000);
         chk(rd, 32'(istat));
         chk({31'h0, irq_out}, {31'h0, (istat & imask) != 0});
      end
      conclude();
   end
   // watchdog: the whole sequence needs well under 100 us
   initial begin
      #100000;
      err_total++;
      conclude();
   end
endmodule : transaction_status_flags_tb
